// ### hw/ccbi_dev.sv
// How it works
// - address strobe only with valid address
// - early write one clock before write
// - read high for reads, low writes
// - lane strobes; byte write copied both lanes
// - 8-bit mode: upper strobe negated, lanes ignored
// - combined strobe is either lane strobe
// - acknowledge latches read data, ends cycle
// - size code 10 byte, 01 word
// - lock held low through read-modify-write
// - two-wire system keeps grant taken negated
// - request taken anytime, grant can come mid-cycle
// - new master waits for four conditions
// - priority inputs decoded, level 7 top
// - levels 1-6 above mask, 7 always
// - requester holds level until acknowledged
// - bus fault retries or raises exception
// - reset instruction drives reset out only
// - halt stops after cycle; double fault drives halted output
// - width select sampled during reset
// - quiesce floats outputs except size code, drives test clock and sequencer status low; clock echoes
// - test clock ten cycles, six low four high
// - autovector only during interrupt acknowledge
// - acknowledge puts level on A3-A1, rest high
// core end of the bus; user side issues one transfer at a time
// assumes the system end shares i_sys_clk
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`include "ccbi_defines.svh"
module ccbi_dev (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  ccbi_if.dev              bus,
  input  wire logic        i_wide_sel,
  input  wire logic        i_quiesce_n,
  input  wire logic        i_start,
  input  wire logic [1:0]  i_op,
  input  wire logic        i_byte,
  input  wire logic        i_lock,
  input  wire logic [31:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [2:0]  i_irq_mask,
  input  wire logic        i_reset_cmd,
  input  wire logic        i_double_fault,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_fault,
  output logic             o_retry,
  output logic             o_autovec,
  output logic [15:0]      o_rdata,
  output logic             o_wide,
  output logic             o_irq_valid,
  output logic [2:0]       o_irq_level
);
  typedef struct packed {
    ccbi_pkg::ccbi_state_t state;
    logic [31:0] addr;
    logic        as_n;
    logic        rw;
    logic        erw_n;
    logic        ub_n;
    logic        lb_n;
    logic [1:0]  siz;
    logic        lock_n;
    logic [15:0] dout;
    logic        doe;
    logic        bg_n;
    logic        halted_n;
    logic [7:0]  rst_cnt;
    logic [3:0]  ring;
    logic        tck;
    logic [10:0] s1;
    logic [10:0] s2;
    logic        busy;
    logic        done;
    logic        fault;
    logic        retry;
    logic        avec;
    logic [15:0] rdata;
    logic        ivalid;
    logic [2:0]  ilevel;
    logic        wr;
    logic        byte_op;
    logic        a0;
  } ccbi_dev_st_t;
  ccbi_dev_st_t st, next_st;
  logic        ack, flt, hlt, req, avc;
  logic [2:0]  lvl;
  logic [15:0] rd;
  always_comb begin
    next_st = st;
    next_st.s1 = {bus.transfer_ack_n, bus.bus_fault_n,
                  bus.halt_request_in_n, bus.bus_req_n, bus.grant_taken_n,
                  bus.auto_vector_req_n, bus.irq_priority_n, 2'b00};
    next_st.s2 = st.s1;
    ack = !st.s2[10];
    flt = !st.s2[9];
    hlt = !st.s2[8];
    req = !st.s2[7];
    avc = !st.s2[5];
    lvl = ~st.s2[4:2];
    next_st.done = 1'b0;
    next_st.fault = 1'b0;
    next_st.retry = 1'b0;
    next_st.avec = 1'b0;
    next_st.ivalid = (lvl == `CCBI_IRQ_NMI) ||
                     (lvl != `CCBI_IRQ_NONE && i_irq_mask < lvl);
    next_st.ilevel = lvl;
    next_st.ring = (st.ring == `CCBI_TCK_PERIOD - 4'd1) ? 4'd0 :
                   st.ring + 4'd1;
    next_st.tck = next_st.ring >= `CCBI_TCK_LOW;
    if (i_reset_cmd) begin
      next_st.rst_cnt = `CCBI_RST_OUT_CYCLES;
    end else if (st.rst_cnt != 8'd0) begin
      next_st.rst_cnt = st.rst_cnt - 8'd1;
    end
    next_st.halted_n = !i_double_fault && st.halted_n;
    // no grant between an accepted start and its address strobe
    next_st.bg_n = !req || st.state == ccbi_pkg::CCBI_ADDR;
    rd = o_wide ? bus.data : {8'h00, bus.data[7:0]};
    case (st.state)
      ccbi_pkg::CCBI_IDLE: begin
        next_st.busy = 1'b0;
        if (i_start && !req && !hlt && st.halted_n &&
            st.s2[6]) begin
          next_st.busy = 1'b1;
          next_st.wr = i_op == ccbi_pkg::CCBI_OP_WRITE;
          next_st.byte_op = i_byte || !o_wide;
          next_st.a0 = i_addr[0];
          if (i_op == ccbi_pkg::CCBI_OP_IACK) begin
            next_st.addr = {28'hfffffff, i_addr[3:1], 1'b1};
          end else begin
            next_st.addr = i_addr;
          end
          next_st.siz = (i_byte || !o_wide) ? `CCBI_SIZE_BYTE :
                        `CCBI_SIZE_WORD;
          next_st.lock_n = !i_lock;
          next_st.dout = i_byte ? {i_wdata[7:0], i_wdata[7:0]} :
                         i_wdata;
          next_st.state = ccbi_pkg::CCBI_ADDR;
        end else if (!i_lock) begin
          next_st.lock_n = 1'b1;
        end
      end
      ccbi_pkg::CCBI_ADDR: begin
        next_st.as_n = 1'b0;
        next_st.erw_n = !st.wr;
        next_st.state = ccbi_pkg::CCBI_STRB;
      end
      ccbi_pkg::CCBI_STRB: begin
        next_st.rw = !st.wr;
        next_st.doe = st.wr;
        next_st.ub_n = !(o_wide && (!st.byte_op || !st.a0));
        next_st.lb_n = !(!st.byte_op || st.a0 || !o_wide);
        next_st.state = ccbi_pkg::CCBI_WAIT;
      end
      ccbi_pkg::CCBI_WAIT: begin
        if (flt) begin
          next_st.fault = !hlt;
          next_st.retry = hlt;
          next_st.state = ccbi_pkg::CCBI_DONE;
        end else if (ack || avc) begin
          next_st.rdata = rd;
          next_st.avec = avc;
          next_st.done = 1'b1;
          next_st.state = ccbi_pkg::CCBI_DONE;
        end
        if (flt || ack || avc) begin
          next_st.doe = 1'b0;
          next_st.as_n = 1'b1;
          next_st.ub_n = 1'b1;
          next_st.lb_n = 1'b1;
          next_st.rw = 1'b1;
          next_st.erw_n = 1'b1;
        end
      end
      ccbi_pkg::CCBI_DONE: begin
        if (!ack && !flt) begin
          next_st.state = hlt ? ccbi_pkg::CCBI_HALT :
                          ccbi_pkg::CCBI_IDLE;
        end
      end
      ccbi_pkg::CCBI_HALT: begin
        if (!hlt) begin
          next_st.state = ccbi_pkg::CCBI_IDLE;
        end
      end
      default: begin
        next_st.state = ccbi_pkg::CCBI_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st <= '0;
      st.as_n <= 1'b1;
      st.rw <= 1'b1;
      st.erw_n <= 1'b1;
      st.ub_n <= 1'b1;
      st.lb_n <= 1'b1;
      st.siz <= `CCBI_SIZE_WORD;
      st.lock_n <= 1'b1;
      st.bg_n <= 1'b1;
      st.halted_n <= 1'b1;
      st.s1 <= 11'h7fc;
      st.s2 <= 11'h7fc;
      st.state <= ccbi_pkg::CCBI_IDLE;
    end else begin
      st <= next_st;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_wide <= i_wide_sel;
    end
  end
  logic q;
  assign q = !i_quiesce_n;
  assign bus.addr = q ? 32'hffffffff : st.addr;
  assign bus.addr_valid_strobe_n = q | st.as_n;
  assign bus.read_not_write = q | st.rw;
  assign bus.early_write_ind_n = q | st.erw_n;
  assign bus.high_byte_strobe_n = q | st.ub_n | !o_wide;
  assign bus.low_byte_strobe_n = q | st.lb_n;
  assign bus.any_byte_strobe_n = q | (st.ub_n & st.lb_n);
  assign bus.transfer_size = st.siz;
  assign bus.indivisible_seq_n = q | st.lock_n;
  assign bus.dev_data_o = st.dout;
  assign bus.dev_data_oe = !q && st.doe;
  assign bus.bus_grant_n = q | st.bg_n;
  assign bus.halted_out_n = q | st.halted_n;
  assign bus.system_reset_out_n = q | (st.rst_cnt == 8'd0);
  assign bus.ring_test_clock = !q && st.tck;
  assign bus.sequencer_status_n = !q && st.halted_n;
  assign bus.clock_echo = i_sys_clk;
  assign o_busy = st.busy;
  assign o_done = st.done;
  assign o_fault = st.fault;
  assign o_retry = st.retry;
  assign o_autovec = st.avec;
  assign o_rdata = st.rdata;
  assign o_irq_valid = st.ivalid;
  assign o_irq_level = st.ilevel;
endmodule : ccbi_dev

// ### hw/ccbi_defines.svh
// constants for the core bus interface: timing counts, encodings, widths
// assumes a 10 MHz core clock
`ifndef CCBI_DEFINES_SVH
`define CCBI_DEFINES_SVH
`define CCBI_CLK_PERIOD_NS   100
`define CCBI_TCK_PERIOD      4'd10
`define CCBI_TCK_LOW         4'd6
`define CCBI_SIZE_BYTE       2'b10
`define CCBI_SIZE_WORD       2'b01
`define CCBI_IRQ_NONE        3'h0
`define CCBI_IRQ_NMI         3'h7
`define CCBI_RST_OUT_CYCLES  8'd124
`define CCBI_AW              32
`define CCBI_DW              16
`endif

// ### hw/ccbi_pkg.sv
// types used by the core end of the core bus interface and its testbench
// assumes ccbi_defines.svh beside it
package ccbi_pkg;
  typedef enum logic [2:0] {
    CCBI_IDLE  = 3'b000,
    CCBI_ADDR  = 3'b001,
    CCBI_STRB  = 3'b010,
    CCBI_WAIT  = 3'b011,
    CCBI_DONE  = 3'b100,
    CCBI_HALT  = 3'b101
  } ccbi_state_t;
  typedef enum logic [1:0] {
    CCBI_OP_READ = 2'b00,
    CCBI_OP_WRITE = 2'b01,
    CCBI_OP_IACK = 2'b10
  } ccbi_op_t;
endpackage : ccbi_pkg

// ### hw/ccbi_if.sv
// pin bundle between core end and system end; resolves the data bus
// assumes both ends clocked by one core clock
interface ccbi_if;
  logic [31:0] addr;
  logic        addr_valid_strobe_n;
  logic        read_not_write;
  logic        early_write_ind_n;
  logic        high_byte_strobe_n;
  logic        low_byte_strobe_n;
  logic        any_byte_strobe_n;
  logic [1:0]  transfer_size;
  logic        indivisible_seq_n;
  logic [15:0] dev_data_o;
  logic        dev_data_oe;
  logic [15:0] sys_data_o;
  logic        sys_data_oe;
  logic [15:0] data;
  logic        transfer_ack_n;
  logic        bus_req_n;
  logic        bus_grant_n;
  logic        grant_taken_n;
  logic [2:0]  irq_priority_n;
  logic        bus_fault_n;
  logic        halt_request_in_n;
  logic        halted_out_n;
  logic        system_reset_out_n;
  logic        auto_vector_req_n;
  logic        ring_test_clock;
  logic        sequencer_status_n;
  logic        clock_echo;
  // wire level from the enables; undriven bus pulls high
  assign data = dev_data_oe ? dev_data_o :
                (sys_data_oe ? sys_data_o : 16'hffff);
  modport dev (
    output addr, addr_valid_strobe_n, read_not_write, early_write_ind_n,
    output high_byte_strobe_n, low_byte_strobe_n, any_byte_strobe_n,
    output transfer_size, indivisible_seq_n, dev_data_o, dev_data_oe,
    output bus_grant_n, halted_out_n, system_reset_out_n,
    output ring_test_clock, sequencer_status_n, clock_echo,
    input  data, transfer_ack_n, bus_req_n, grant_taken_n,
    input  irq_priority_n, bus_fault_n, halt_request_in_n,
    input  auto_vector_req_n
  );
  modport sys (
    input  addr, addr_valid_strobe_n, read_not_write, early_write_ind_n,
    input  high_byte_strobe_n, low_byte_strobe_n, any_byte_strobe_n,
    input  transfer_size, indivisible_seq_n, data, bus_grant_n,
    input  halted_out_n, system_reset_out_n,
    output sys_data_o, sys_data_oe, transfer_ack_n, bus_req_n,
    output grant_taken_n, irq_priority_n, bus_fault_n,
    output halt_request_in_n, auto_vector_req_n
  );
endinterface : ccbi_if

// ### hw/ccbi_sys.sv
// system end: slave memory port, arbiter request, interrupt and halt lines
// assumes the core end on the same clock; user side drives plain ports
module ccbi_sys (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  ccbi_if.sys              bus,
  input  wire logic        i_ack,
  input  wire logic        i_fault,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_want_bus,
  input  wire logic        i_three_wire,
  input  wire logic [2:0]  i_irq_level,
  input  wire logic        i_autovec,
  input  wire logic        i_halt,
  output logic             o_cycle,
  output logic             o_we,
  output logic [31:0]      o_addr,
  output logic [15:0]      o_wdata,
  output logic [1:0]       o_lanes,
  output logic             o_owner
);
  typedef struct packed {
    logic        ack;
    logic        fault;
    logic        drive;
    logic [15:0] rdata;
    logic        req;
    logic        taken;
    logic [2:0]  irq;
    logic        avec;
    logic        halt;
    logic        cycle;
    logic        we;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic [1:0]  lanes;
  } ccbi_sys_st_t;
  ccbi_sys_st_t st, next_st;
  logic strobing;
  logic is_iack;
  always_comb begin
    next_st = st;
    strobing = !bus.any_byte_strobe_n && !bus.addr_valid_strobe_n;
    is_iack = bus.addr[31:4] == 28'hfffffff && bus.addr[0];
    next_st.cycle = strobing;
    next_st.we = !bus.read_not_write;
    next_st.addr = bus.addr;
    next_st.wdata = bus.data;
    next_st.lanes = {!bus.high_byte_strobe_n, !bus.low_byte_strobe_n};
    next_st.ack = strobing && i_ack && !i_fault;
    next_st.fault = strobing && i_fault;
    next_st.drive = strobing && bus.read_not_write && i_ack;
    next_st.rdata = i_rdata;
    next_st.req = i_want_bus && !st.taken;
    if (!i_three_wire || !i_want_bus) begin
      next_st.taken = 1'b0;
    end else if (!bus.bus_grant_n && bus.addr_valid_strobe_n &&
                 bus.transfer_ack_n && !st.taken) begin
      next_st.taken = 1'b1;
    end
    next_st.irq = i_irq_level;
    next_st.avec = i_autovec && strobing && is_iack;
    next_st.halt = i_halt;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign bus.transfer_ack_n = !st.ack;
  assign bus.bus_fault_n = !st.fault;
  assign bus.sys_data_oe = st.drive;
  assign bus.sys_data_o = st.rdata;
  assign bus.bus_req_n = !st.req;
  assign bus.grant_taken_n = !st.taken;
  assign bus.irq_priority_n = ~st.irq;
  assign bus.auto_vector_req_n = !st.avec;
  assign bus.halt_request_in_n = !st.halt;
  assign o_cycle = st.cycle;
  assign o_we = st.we;
  assign o_addr = st.addr;
  assign o_wdata = st.wdata;
  assign o_lanes = st.lanes;
  assign o_owner = st.taken;
endmodule : ccbi_sys

// ### tb/ccbi_sva.sv
// ccbi_sva: concurrent checks on the wires between the two ends
// assumes one clock domain; placed in testbench beside the interface
`include "ccbi_defines.svh"
module ccbi_sva (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        addr_valid_strobe_n,
  input wire logic        read_not_write,
  input wire logic        early_write_ind_n,
  input wire logic        high_byte_strobe_n,
  input wire logic        low_byte_strobe_n,
  input wire logic        any_byte_strobe_n,
  input wire logic [1:0]  transfer_size,
  input wire logic        dev_data_oe,
  input wire logic [15:0] data,
  input wire logic        bus_req_n,
  input wire logic        bus_grant_n,
  input wire logic        ring_test_clock
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence tck_high;
    ring_test_clock [*4];
  endsequence
  sequence tck_low;
    !ring_test_clock [*6];
  endsequence
  AST_ANY_STROBE: assert property (
    any_byte_strobe_n == (high_byte_strobe_n & low_byte_strobe_n))
    else $error("combined strobe mismatch");
  AST_STROBE_IN_AS: assert property (
    !any_byte_strobe_n |-> !addr_valid_strobe_n)
    else $error("data strobe without address strobe");
  AST_EARLY_FIRST: assert property (
    $fell(read_not_write) |-> !$past(early_write_ind_n))
    else $error("early write not ahead of write");
  AST_NEG_TOGETHER: assert property (
    $rose(early_write_ind_n) |-> $rose(read_not_write))
    else $error("write lines negated apart");
  AST_WRITE_DRIVES: assert property (
    !read_not_write && !any_byte_strobe_n |-> dev_data_oe)
    else $error("write without data drive");
  AST_SIZE_CODE: assert property (
    !any_byte_strobe_n |-> transfer_size ==
      ((high_byte_strobe_n | low_byte_strobe_n) ?
        `CCBI_SIZE_BYTE : `CCBI_SIZE_WORD))
    else $error("size code wrong");
  AST_BYTE_COPY: assert property (
    !read_not_write && !high_byte_strobe_n && low_byte_strobe_n
      |-> data[15:8] == data[7:0])
    else $error("byte write not on both lanes");
  AST_GRANT_PROMPT: assert property (
    $fell(bus_req_n) |-> ##[1:16] (!bus_grant_n || bus_req_n))
    else $error("grant late");
  AST_NO_CYCLE_GRANTED: assert property (
    !bus_grant_n && addr_valid_strobe_n |=> addr_valid_strobe_n)
    else $error("cycle started after grant");
  AST_RING: assert property (
    $rose(ring_test_clock) |-> tck_high ##1 tck_low ##1 ring_test_clock)
    else $error("test clock period wrong");
endmodule // ccbi_sva

// ### tb/testbench.sv
// testbench: drives both ends of the core bus across one interface
// assumes both ends share i_sys_clk; checker watches the wires
`include "ccbi_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_sys_clk = 1'b0, i_rst = 1'b1;
  logic        wide = 1'b1, start = 1'b0, byt = 1'b0;
  logic        rcmd = 1'b0, dfault = 1'b0, ack = 1'b1, flt = 1'b0;
  logic        want = 1'b0, three = 1'b0, avec = 1'b0;
  logic [1:0]  op = 2'h0;
  logic [31:0] addr = 32'h0, cap_addr;
  logic [15:0] wdata = 16'h0, rdata = 16'h0, cap_data, rd_o;
  logic [2:0]  mask = 3'h3, irq = 3'h0, irql;
  logic [1:0]  cap_size;
  logic        busy, done, fault, autov, wide_o, irqv, owner;
  logic        seen_hi = 1'b0, got_av = 1'b0;
  logic        lck = 1'b0, quiet_n = 1'b1, halt = 1'b0, retry;
  logic        s_cycle, s_we, cap_we;
  logic [1:0]  s_lanes, cap_lanes;
  logic [31:0] s_addr, cap_saddr;
  logic [15:0] s_wdata, cap_swdata;
  int          failures = 0, checks_done = 0;
  ccbi_if bus ();
  always #50 i_sys_clk = ~i_sys_clk;
  ccbi_dev ccbi_dev_i (.i_sys_clk, .i_rst, .bus(bus), .i_wide_sel(wide),
    .i_quiesce_n(quiet_n), .i_start(start), .i_op(op), .i_byte(byt),
    .i_lock(lck), .i_addr(addr), .i_wdata(wdata), .i_irq_mask(mask),
    .i_reset_cmd(rcmd), .i_double_fault(dfault), .o_busy(busy),
    .o_done(done), .o_fault(fault), .o_retry(retry), .o_autovec(autov),
    .o_rdata(rd_o), .o_wide(wide_o), .o_irq_valid(irqv),
    .o_irq_level(irql));
  ccbi_sys ccbi_sys_i (.i_sys_clk, .i_rst, .bus(bus), .i_ack(ack),
    .i_fault(flt), .i_rdata(rdata), .i_want_bus(want),
    .i_three_wire(three), .i_irq_level(irq), .i_autovec(avec),
    .i_halt(halt), .o_cycle(s_cycle), .o_we(s_we), .o_addr(s_addr),
    .o_wdata(s_wdata), .o_lanes(s_lanes), .o_owner(owner));
  ccbi_sva ccbi_sva_i (.i_sys_clk, .i_rst,
    .addr_valid_strobe_n(bus.addr_valid_strobe_n),
    .read_not_write(bus.read_not_write),
    .early_write_ind_n(bus.early_write_ind_n),
    .high_byte_strobe_n(bus.high_byte_strobe_n),
    .low_byte_strobe_n(bus.low_byte_strobe_n),
    .any_byte_strobe_n(bus.any_byte_strobe_n),
    .transfer_size(bus.transfer_size), .dev_data_oe(bus.dev_data_oe),
    .data(bus.data), .bus_req_n(bus.bus_req_n),
    .bus_grant_n(bus.bus_grant_n), .ring_test_clock(bus.ring_test_clock));
  // wire monitor: what stood on the bus during the last strobe
  always @(posedge i_sys_clk) begin
    if (!bus.any_byte_strobe_n) begin
      cap_data <= bus.data;
      cap_size <= bus.transfer_size;
      cap_addr <= bus.addr;
    end
    if (!bus.high_byte_strobe_n) seen_hi <= 1'b1;
    if (autov) got_av <= 1'b1;
    if (s_cycle) begin
      cap_lanes <= s_lanes;
      cap_we <= s_we;
      cap_saddr <= s_addr;
      cap_swdata <= s_wdata;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [1:0] o, input logic b,
                    input logic [31:0] a, input logic [15:0] d);
    while (busy !== 1'b0) @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    op <= o;
    byt <= b;
    addr <= a;
    wdata <= d;
    start <= 1'b1;
    @(posedge i_sys_clk);
    start <= 1'b0;
  endtask
  task automatic wait_hi(ref logic s);
    int n = 0;
    while (s !== 1'b1 && n < 300) begin
      @(posedge i_sys_clk);
      n++;
    end
    check(32'(n < 300), 32'h1);
  endtask
  task automatic t_word;
    lck <= 1'b1;
    go(ccbi_pkg::CCBI_OP_WRITE, 1'b0, 32'h100, 16'h1234);
    wait_hi(done);
    check(cap_data, 32'h1234);
    check(cap_size, `CCBI_SIZE_WORD);
    check(bus.indivisible_seq_n, 32'h0);
    rdata <= 16'hbeef;
    go(ccbi_pkg::CCBI_OP_READ, 1'b0, 32'h102, 16'h0);
    wait_hi(done);
    check(rd_o, 32'hbeef);
    lck <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    check(bus.indivisible_seq_n, 32'h1);
  endtask
  task automatic t_byte;
    seen_hi <= 1'b0;
    go(ccbi_pkg::CCBI_OP_WRITE, 1'b1, 32'h200, 16'h00a5);
    wait_hi(done);
    check(cap_data, 32'ha5a5);
    check(cap_size, `CCBI_SIZE_BYTE);
    check(seen_hi, 32'h1);
    check(cap_lanes, 32'h2);
    check(cap_we, 32'h1);
    check(cap_swdata, 32'ha5a5);
    check(cap_saddr, 32'h200);
  endtask
  task automatic t_slow_and_fault;
    ack <= 1'b0;
    go(ccbi_pkg::CCBI_OP_READ, 1'b0, 32'h104, 16'h0);
    repeat (12) @(posedge i_sys_clk);
    check(busy, 32'h1);
    ack <= 1'b1;
    wait_hi(done);
    ack <= 1'b0;
    flt <= 1'b1;
    go(ccbi_pkg::CCBI_OP_READ, 1'b0, 32'h106, 16'h0);
    wait_hi(fault);
    go(ccbi_pkg::CCBI_OP_READ, 1'b0, 32'h10a, 16'h0);
    halt <= 1'b1;
    wait_hi(retry);
    repeat (3) @(posedge i_sys_clk);
    check(bus.addr_valid_strobe_n, 32'h1);
    check(busy, 32'h1);
    halt <= 1'b0;
    flt <= 1'b0;
    ack <= 1'b1;
  endtask
  task automatic t_arb;
    want <= 1'b1;
    three <= 1'b1;
    repeat (7) @(posedge i_sys_clk);
    check(bus.bus_grant_n, 32'h0);
    check(bus.grant_taken_n, 32'h0);
    check(owner, 32'h1);
    go(ccbi_pkg::CCBI_OP_READ, 1'b0, 32'h108, 16'h0);
    repeat (10) @(posedge i_sys_clk);
    check(busy, 32'h0);
    three <= 1'b0;
    repeat (12) @(posedge i_sys_clk);
    check(bus.grant_taken_n, 32'h1);
    check(bus.bus_grant_n, 32'h0);
    want <= 1'b0;
    repeat (12) @(posedge i_sys_clk);
    check(bus.bus_grant_n, 32'h1);
  endtask
  task automatic t_irq;
    for (int m = 3; m < 8; m += 4) begin
      mask <= 3'(m);
      for (int l = 0; l < 8; l++) begin
        irq <= 3'(l);
        repeat (6) @(posedge i_sys_clk);
        check(irqv, 32'(l == 7 || l > m));
        if (l == 7 || l > m) check(irql, 32'(l));
      end
    end
    irq <= 3'h0;
  endtask
  task automatic t_iack;
    int n = 0;
    avec <= 1'b1;
    go(ccbi_pkg::CCBI_OP_IACK, 1'b0, 32'ha, 16'h0);
    wait_hi(got_av);
    check(cap_addr, 32'hfffffffb);
    avec <= 1'b0;
    @(posedge i_sys_clk);
    rcmd <= 1'b1;
    @(posedge i_sys_clk);
    rcmd <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    while (bus.system_reset_out_n === 1'b0 && n < 400) begin
      @(posedge i_sys_clk);
      n++;
    end
    check(n + 3, `CCBI_RST_OUT_CYCLES);
    check(wide_o, 32'h1);
  endtask
  task automatic t_halt_narrow;
    dfault <= 1'b1;
    @(posedge i_sys_clk);
    dfault <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    check(bus.halted_out_n, 32'h0);
    wide <= 1'b0;
    i_rst <= 1'b1;
    quiet_n <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    check(bus.sequencer_status_n, 32'h0);
    check(bus.addr, 32'hffffffff);
    check(bus.addr_valid_strobe_n, 32'h1);
    quiet_n <= 1'b1;
    repeat (16) @(posedge i_sys_clk);
    check(bus.sequencer_status_n, 32'h1);
    i_rst <= 1'b0;
    seen_hi <= 1'b0;
    rdata <= 16'h12c3;
    repeat (4) @(posedge i_sys_clk);
    check(wide_o, 32'h0);
    go(ccbi_pkg::CCBI_OP_READ, 1'b1, 32'h301, 16'h0);
    wait_hi(done);
    check(rd_o, 32'h00c3);
    check(seen_hi, 32'h0);
    check(cap_lanes, 32'h1);
    check(cap_we, 32'h0);
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    t_word();
    t_byte();
    t_slow_and_fault();
    t_arb();
    t_irq();
    t_iack();
    t_halt_narrow();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    failures++;
    print_verdict();
  end
endmodule // testbench
